// ### accel_regs_pkg.sv
package accel_regs_pkg;

  typedef logic [7:0] addr_t;
  typedef logic [7:0] data_t;

  // Register offsets
  localparam addr_t ADDR_ORIENT_HIGHG = 8'h0c;
  localparam addr_t ADDR_FIFO_FILL = 8'h0e;
  localparam addr_t ADDR_FULL_SCALE = 8'h0f;
  localparam addr_t ADDR_FILTER = 8'h10;
  localparam addr_t ADDR_IRQ_STATUS = 8'h20;
  localparam addr_t ADDR_IRQ_MASK = 8'h21;

  // Reset values
  localparam data_t FULL_SCALE_RST = 8'h03;
  localparam data_t FILTER_RST = 8'h0f;
  localparam data_t IRQ_MASK_RST = 8'h00;

  // Field positions
  localparam int FLAT_POS = 7;
  localparam int ORIENT_LSB = 4;
  localparam int HIGH_SIGN_POS = 3;
  localparam int OVERRUN_POS = 7;
  localparam int RANGE_W = 4;
  localparam int FILTER_W = 5;
  localparam int COUNT_W = 7;

  // Interrupt status bits
  localparam int EV_HIGHG = 0;
  localparam int EV_FLAT = 1;
  localparam int EV_ORIENT = 2;
  localparam int EV_OVERRUN = 3;
  localparam int EV_W = 4;

  // Full-scale codes
  localparam logic [3:0] RANGE_2G = 4'h3;
  localparam logic [3:0] RANGE_4G = 4'h5;
  localparam logic [3:0] RANGE_8G = 4'h8;
  localparam logic [3:0] RANGE_16G = 4'hc;

  // Filter code corners
  localparam logic [4:0] FILTER_LOWEST = 5'h08;
  localparam logic [4:0] FILTER_HIGHEST = 5'h0f;

  // Latch mode encodings
  localparam logic [3:0] LATCH_NONE = 4'h0;
  localparam logic [3:0] LATCH_PERM_A = 4'h7;
  localparam logic [3:0] LATCH_PERM_B = 4'hf;

  // FIFO capacity in frames
  localparam logic [6:0] FIFO_FRAMES = 7'h20;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TEMP_HOLD_NS = 1000;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_CYC =
    HOLD_W'((TEMP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage

// ### latch_flag.sv
`timescale 1ns/1ps
module latch_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trig,
  input wire logic level,
  input wire logic [3:0] mode,
  input wire logic clear,
  output logic flag
);
  import accel_regs_pkg::*;

  logic flag_ff;
  logic nxt_flag;
  logic [HOLD_W-1:0] hold_ff;
  logic [HOLD_W-1:0] nxt_hold;

  wire logic no_latch = (mode == LATCH_NONE);
  wire logic perm = (mode == LATCH_PERM_A) || (mode == LATCH_PERM_B);
  wire logic hold_live = (hold_ff > HOLD_W'(1));

  // Set beats clear so a trigger in the clear cycle survives
  assign nxt_flag = no_latch ? level :
                    trig ? 1'b1 :
                    clear ? 1'b0 :
                    perm ? flag_ff : (flag_ff && hold_live); // [R02]
  assign nxt_hold = trig ? HOLD_CYC :
                    (hold_ff != '0) ? hold_ff - HOLD_W'(1) : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      flag_ff <= nxt_flag; // [R01]
      hold_ff <= nxt_hold;
    end
  end

  assign flag = flag_ff;

  a_trig_sets: assert property (@(posedge clk) disable iff (!rst_n) // [R01]
    trig && !no_latch |=> flag_ff)
    else $error("trigger did not set flag");

  a_follow_level: assert property (@(posedge clk) disable iff (!rst_n) // [R02]
    no_latch |=> flag_ff == $past(level))
    else $error("unlatched flag not following level");

  a_perm_holds: assert property (@(posedge clk) disable iff (!rst_n) // [R02]
    flag_ff && perm && !clear |=> flag_ff)
    else $error("permanent latch dropped");

endmodule

// ### accel_status_config_regs.sv
// Behaviour
// [R01] Detail flags set on engine trigger
// [R02] Latch mode governs high-g and flat bits
// [R03] Host trusts flags only when enabled
// [R04] Flat bit valid only with flat enabled
// [R05] Z orientation: 0 up, 1 down
// [R06] In-plane orientation uses four-code encoding
// [R07] Orientation ignores latch mode, shows present
// [R08] Orientation frozen while blocking is active
// [R09] High-g sign bit: 0 positive
// [R10] Bits 2..0 mark z, y, x axis
// [R11] Overrun cleared only by config write
// [R12] Seven-bit frame counter, zero when empty
// [R13] Counter cleared by draining or config write
// [R14] Range codes select full scale, reset 0011b
// [R15] Host uses only defined range codes
// [R16] Filter code maps to bandwidth, reset 01111b
// [R17] Status writes ignored, reserved bits zero
// [R18] Host writes zero to reserved bits
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module accel_status_config_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire accel_regs_pkg::addr_t addr,
  input wire accel_regs_pkg::data_t wdata,
  input wire logic wr,
  input wire logic rd,
  output accel_regs_pkg::data_t rdata,
  input wire logic [2:0] orient_now,
  input wire logic orient_block,
  input wire logic flat_now,
  input wire logic flat_trig,
  input wire logic flat_en,
  input wire logic high_trig,
  input wire logic high_level,
  input wire logic high_sign_in,
  input wire logic [2:0] high_axis_in,
  input wire logic [3:0] latch_mode,
  input wire logic latch_clear,
  input wire logic fifo_wr,
  input wire logic fifo_rd,
  input wire logic fifo_cfg_wr,
  output logic [3:0] full_scale_select,
  output logic [1:0] range_gsel,
  output logic range_valid,
  output logic [4:0] filter_bandwidth_code,
  output logic [2:0] filter_step,
  output logic irq
);
  import accel_regs_pkg::*;

  // Full-scale code to 0..3 index; unknown codes fall back to 2g
  function automatic logic [1:0] gsel_of(input logic [3:0] code);
    case (code)
      RANGE_4G: gsel_of = 2'h1;
      RANGE_8G: gsel_of = 2'h2;
      RANGE_16G: gsel_of = 2'h3;
      default: gsel_of = 2'h0;
    endcase
  endfunction

  function automatic logic range_known(input logic [3:0] code);
    range_known = (code == RANGE_2G) || (code == RANGE_4G) ||
                  (code == RANGE_8G) || (code == RANGE_16G);
  endfunction

  // Filter code to doubling step: 0 is 7.81 Hz, 7 is 1000 Hz
  function automatic logic [2:0] step_of(input logic [4:0] code);
    if (code[4]) begin
      step_of = 3'h7;
    end else if (code <= FILTER_LOWEST) begin
      step_of = 3'h0;
    end else begin
      step_of = code[2:0] - 3'h0;
    end
  endfunction

  // Reset release through two flops
  logic rst_meta_ff;
  logic rst_n_ff;
  wire logic rst_n = rst_n_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Address decode
  wire logic hit_orient = (addr == ADDR_ORIENT_HIGHG);
  wire logic hit_fifo = (addr == ADDR_FIFO_FILL);
  wire logic hit_range = (addr == ADDR_FULL_SCALE);
  wire logic hit_filter = (addr == ADDR_FILTER);
  wire logic hit_stat = (addr == ADDR_IRQ_STATUS);
  wire logic hit_mask = (addr == ADDR_IRQ_MASK);
  wire logic wr_range = wr && hit_range;
  wire logic wr_filter = wr && hit_filter;
  wire logic wr_stat = wr && hit_stat;
  wire logic wr_mask = wr && hit_mask;

  // Orientation
  logic [2:0] orient_ff;
  logic [2:0] nxt_orient;
  // Bit 2 z face (0 up, 1 down), bits 1:0 in-plane code passed as coded
  assign nxt_orient = orient_block ? orient_ff : orient_now; // [R05] [R06] [R07] [R08]

  // High-g and flat flags through the latch logic
  logic high_flag;
  logic flat_flag;

  latch_flag u_high_latch (
    .clk(clk),
    .rst_n(rst_n),
    .trig(high_trig),
    .level(high_level),
    .mode(latch_mode),
    .clear(latch_clear),
    .flag(high_flag)
  );

  latch_flag u_flat_latch (
    .clk(clk),
    .rst_n(rst_n),
    .trig(flat_trig),
    .level(flat_now),
    .mode(latch_mode),
    .clear(latch_clear),
    .flag(flat_flag)
  );

  // Sign and axes captured at the trigger, shown while the flag stands
  logic [3:0] high_detail_ff;
  logic [3:0] nxt_high_detail;
  assign nxt_high_detail = high_trig ? {high_sign_in, high_axis_in} : high_detail_ff; // [R01] [R09] [R10]

  wire logic [3:0] high_shown = high_detail_ff & {4{high_flag}}; // [R02]
  // Flat reads zero while detection is off, so a stale latch cannot leak
  wire logic flat_shown = flat_flag && flat_en; // [R04]
  wire data_t orient_word = {flat_shown, orient_ff, high_shown};

  // FIFO fill tracking
  logic overrun_ff;
  logic nxt_overrun;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  wire logic fifo_full = (count_ff == FIFO_FRAMES);
  wire logic fifo_empty = (count_ff == '0);
  wire logic overrun_evt = fifo_wr && fifo_full && !fifo_rd;
  wire logic count_up = fifo_wr && !fifo_full && !(fifo_rd && !fifo_empty);
  wire logic count_dn = fifo_rd && !fifo_empty && !fifo_wr;

  // A new overrun in the config write cycle is kept
  assign nxt_overrun = overrun_evt ? 1'b1 : (fifo_cfg_wr ? 1'b0 : overrun_ff); // [R11]
  assign nxt_count = fifo_cfg_wr ? '0 :
                     count_up ? count_ff + COUNT_W'(1) :
                     count_dn ? count_ff - COUNT_W'(1) : count_ff; // [R12] [R13]
  wire data_t fifo_word = {overrun_ff, count_ff};

  // Configuration registers, reserved bits not stored
  logic [RANGE_W-1:0] range_ff;
  logic [FILTER_W-1:0] filter_ff;
  wire logic [RANGE_W-1:0] nxt_range = wr_range ? wdata[RANGE_W-1:0] : range_ff; // [R14]
  wire logic [FILTER_W-1:0] nxt_filter = wr_filter ? wdata[FILTER_W-1:0] : filter_ff; // [R16]

  // Interrupt status, write one to clear, set wins
  logic orient_moved_ff;
  logic [EV_W-1:0] stat_ff;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] nxt_stat;
  logic [EV_W-1:0] nxt_mask;
  assign events[EV_HIGHG] = high_trig;
  assign events[EV_FLAT] = flat_trig;
  assign events[EV_ORIENT] = orient_moved_ff;
  assign events[EV_OVERRUN] = overrun_evt;
  assign nxt_stat = events | (stat_ff & ~(wr_stat ? wdata[EV_W-1:0] : '0));
  assign nxt_mask = wr_mask ? wdata[EV_W-1:0] : mask_ff;
  wire logic nxt_irq = |(nxt_stat & nxt_mask);

  // Read mux; unmapped reads give zero
  data_t rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_orient) begin
      rd_mux = orient_word;
    end else if (hit_fifo) begin
      rd_mux = fifo_word;
    end else if (hit_range) begin
      rd_mux = data_t'(range_ff); // [R17]
    end else if (hit_filter) begin
      rd_mux = data_t'(filter_ff); // [R17]
    end else if (hit_stat) begin
      rd_mux = data_t'(stat_ff);
    end else if (hit_mask) begin
      rd_mux = data_t'(mask_ff);
    end
  end

  // Status words have no bus write path; fifo_cfg_wr clears overrun and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_ff <= '0;
      orient_moved_ff <= 1'b0;
      high_detail_ff <= '0;
      overrun_ff <= 1'b0;
      count_ff <= '0;
    end else begin
      orient_ff <= nxt_orient;
      orient_moved_ff <= (nxt_orient != orient_ff);
      high_detail_ff <= nxt_high_detail;
      overrun_ff <= nxt_overrun;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      range_ff <= FULL_SCALE_RST[RANGE_W-1:0];
      filter_ff <= FILTER_RST[FILTER_W-1:0];
      mask_ff <= IRQ_MASK_RST[EV_W-1:0];
      stat_ff <= '0;
    end else begin
      range_ff <= nxt_range;
      filter_ff <= nxt_filter;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
    end
  end

  // Decoded outputs lag the register by nothing: same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
      irq <= 1'b0;
      full_scale_select <= FULL_SCALE_RST[RANGE_W-1:0];
      range_gsel <= 2'h0;
      range_valid <= 1'b1;
      filter_bandwidth_code <= FILTER_RST[FILTER_W-1:0];
      filter_step <= 3'h7;
    end else begin
      rdata <= rd ? rd_mux : '0;
      irq <= nxt_irq;
      full_scale_select <= nxt_range;
      range_gsel <= gsel_of(nxt_range); // [R14]
      range_valid <= range_known(nxt_range);
      filter_bandwidth_code <= nxt_filter;
      filter_step <= step_of(nxt_filter); // [R16]
    end
  end

  a_orient_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
    orient_block |=> $stable(orient_ff))
    else $error("orientation changed while blocked");

  a_orient_follow: assert property (@(posedge clk) disable iff (!rst_n) // [R07]
    !orient_block |=> orient_ff == $past(orient_now))
    else $error("orientation not tracking present value");

  a_flat_gated: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
    rd && hit_orient && !flat_en |=> rdata[FLAT_POS] == 1'b0)
    else $error("flat bit set with detection off");

  a_high_capture: assert property (@(posedge clk) disable iff (!rst_n) // [R09]
    high_trig |=> high_detail_ff == $past({high_sign_in, high_axis_in}))
    else $error("high-g detail not captured");

  a_high_read: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    rd && hit_orient |=> rdata[3:0] == $past(high_shown))
    else $error("high-g detail read mismatch");

  a_overrun_set: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    overrun_evt |=> overrun_ff)
    else $error("overrun not flagged");

  a_overrun_keep: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    overrun_ff && !fifo_cfg_wr |=> overrun_ff)
    else $error("overrun cleared without config write");

  a_count_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    fifo_cfg_wr |=> count_ff == '0)
    else $error("frame counter not cleared");

  a_count_limit: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    count_ff <= FIFO_FRAMES)
    else $error("frame counter beyond capacity");

  a_range_write: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    wr_range |=> full_scale_select == $past(wdata[RANGE_W-1:0]))
    else $error("range write lost");

  a_filter_read: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
    rd && hit_filter |=> rdata[7:FILTER_W] == '0)
    else $error("reserved filter bits read nonzero");

  a_filter_top: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    wr_filter && wdata[4] |=> filter_step == 3'h7)
    else $error("top filter codes not at 1000 Hz");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq == |(stat_ff & mask_ff))
    else $error("interrupt not matching status");

  a_count_drain: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    fifo_rd && !fifo_wr && !fifo_cfg_wr && count_ff == COUNT_W'(1) |=> count_ff == '0)
    else $error("last frame read did not empty counter");

  a_count_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    fifo_wr && fifo_full && !fifo_cfg_wr |=> count_ff == FIFO_FRAMES)
    else $error("frame counter moved while full");

  a_status_ro: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
    wr && hit_fifo && !fifo_cfg_wr && !fifo_wr && !fifo_rd |=> $stable({overrun_ff, count_ff}))
    else $error("fifo status changed by a bus write");

  a_gsel_map: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    wr_range && wdata[RANGE_W-1:0] == RANGE_16G |=> range_gsel == 2'h3 && range_valid)
    else $error("16g code not decoded");

  a_step_low: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    wr_filter && wdata[4:3] == 2'b00 |=> filter_step == 3'h0)
    else $error("low filter codes not at lowest step");

  a_orient_event: assert property (@(posedge clk) disable iff (!rst_n)
    orient_ff != $past(orient_ff) |=> stat_ff[EV_ORIENT])
    else $error("orientation change not flagged");

  c_overrun: cover property (@(posedge clk) disable iff (!rst_n)
    overrun_evt ##[1:20] fifo_cfg_wr);

  c_orient_block: cover property (@(posedge clk) disable iff (!rst_n)
    orient_block && (orient_now != orient_ff) ##1 !orient_block);

  c_high_read: cover property (@(posedge clk) disable iff (!rst_n)
    high_trig ##[1:10] (rd && hit_orient));

  c_irq: cover property (@(posedge clk) disable iff (!rst_n)
    irq ##1 wr_stat ##1 !irq);

  c_fifo_drain: cover property (@(posedge clk) disable iff (!rst_n)
    count_ff == COUNT_W'(1) && fifo_rd && !fifo_wr ##1 fifo_empty);

endmodule

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output accel_regs_pkg::addr_t addr,
  output accel_regs_pkg::data_t wdata,
  output logic wr,
  output logic rd,
  input wire accel_regs_pkg::data_t rdata
);
  import accel_regs_pkg::*;
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Callers pass only defined range codes and zero reserved bits
  task automatic write_reg(input addr_t a, input data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic read_reg(input addr_t a, output data_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// ### test_accel_status_config_regs.sv
`timescale 1ns/1ps
module test_accel_status_config_regs;
  import accel_regs_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  addr_t addr;
  data_t wdata;
  data_t rdata;
  logic wr;
  logic rd;
  logic [2:0] orient_now = 3'h0;
  logic orient_block = 1'b0;
  logic flat_now = 1'b0;
  logic flat_trig = 1'b0;
  logic flat_en = 1'b0;
  logic high_trig = 1'b0;
  logic high_level = 1'b0;
  logic high_sign_in = 1'b0;
  logic [2:0] high_axis_in = 3'h0;
  logic [3:0] latch_mode = 4'h0;
  logic latch_clear = 1'b0;
  logic fifo_wr = 1'b0;
  logic fifo_rd = 1'b0;
  logic fifo_cfg_wr = 1'b0;
  logic [3:0] full_scale_select;
  logic [1:0] range_gsel;
  logic range_valid;
  logic [4:0] filter_bandwidth_code;
  logic [2:0] filter_step;
  logic irq;
  int bad_count = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  accel_status_config_regs dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .orient_now(orient_now), .orient_block(orient_block), .flat_now(flat_now),
    .flat_trig(flat_trig), .flat_en(flat_en), .high_trig(high_trig), .high_level(high_level),
    .high_sign_in(high_sign_in), .high_axis_in(high_axis_in), .latch_mode(latch_mode),
    .latch_clear(latch_clear), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_cfg_wr(fifo_cfg_wr),
    .full_scale_select(full_scale_select), .range_gsel(range_gsel), .range_valid(range_valid),
    .filter_bandwidth_code(filter_bandwidth_code), .filter_step(filter_step), .irq(irq));
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string name, input data_t exp, input data_t got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic rd_chk(input string name, input addr_t a, input data_t exp);
    data_t v;
    host.read_reg(a, v);
    chk(name, exp, v);
  endtask
  task automatic t_reset();
    rd_chk("range reset", ADDR_FULL_SCALE, 8'h03);
    rd_chk("filter reset", ADDR_FILTER, 8'h0f);
    rd_chk("unmapped read", 8'h30, 8'h00);
    chk("irq reset", 8'h00, {7'h0, irq});
  endtask
  task automatic t_range();
    logic [3:0] codes [4] = '{4'h3, 4'h5, 4'h8, 4'hc};
    for (int i = 0; i < 4; i++) begin
      host.write_reg(ADDR_FULL_SCALE, {4'h0, codes[i]});
      rd_chk("range code", ADDR_FULL_SCALE, {4'h0, codes[i]});
      chk("range gsel", 8'(i), {6'h0, range_gsel});
      chk("range select", {4'h0, codes[i]}, {4'h0, full_scale_select});
      chk("range valid", 8'h01, {7'h0, range_valid});
    end
  endtask
  task automatic t_filter();
    logic [4:0] codes [7] = '{5'h00, 5'h08, 5'h09, 5'h0a, 5'h0f, 5'h10, 5'h1f};
    logic [2:0] steps [7] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h7, 3'h7, 3'h7};
    for (int i = 0; i < 7; i++) begin
      host.write_reg(ADDR_FILTER, {3'h0, codes[i]});
      rd_chk("filter code", ADDR_FILTER, {3'h0, codes[i]});
      chk("filter step", {5'h0, steps[i]}, {5'h0, filter_step});
      chk("filter code out", {3'h0, codes[i]}, {3'h0, filter_bandwidth_code});
    end
  endtask
  task automatic t_orient();
    tick(1);
    latch_mode <= LATCH_PERM_A;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      orient_now <= 3'(i);
      tick(2);
      rd_chk("orient plane", ADDR_ORIENT_HIGHG, 8'(i << 4));
    end
    tick(1);
    orient_now <= 3'b101;
    tick(2);
  endtask
  // Flat bit checked set while its function is enabled and zero once it is disabled
  task automatic t_high_flat();
    flat_en <= 1'b1;
    high_sign_in <= 1'b1;
    high_axis_in <= 3'b100;
    high_trig <= 1'b1;
    flat_trig <= 1'b1;
    tick(1);
    high_trig <= 1'b0;
    flat_trig <= 1'b0;
    rd_chk("high flat status", ADDR_ORIENT_HIGHG, 8'hdc);
    host.write_reg(ADDR_ORIENT_HIGHG, 8'h00);
    rd_chk("status after write", ADDR_ORIENT_HIGHG, 8'hdc);
    tick(1);
    flat_en <= 1'b0;
    tick(1);
    rd_chk("flat disabled", ADDR_ORIENT_HIGHG, 8'h5c);
    tick(1);
    latch_clear <= 1'b1;
    tick(1);
    latch_clear <= 1'b0;
    rd_chk("status after clear", ADDR_ORIENT_HIGHG, 8'h50);
  endtask
  task automatic t_block();
    tick(1);
    orient_block <= 1'b1;
    orient_now <= 3'b010;
    tick(2);
    rd_chk("orient blocked", ADDR_ORIENT_HIGHG, 8'h50);
    tick(1);
    orient_block <= 1'b0;
    tick(2);
    rd_chk("orient released", ADDR_ORIENT_HIGHG, 8'h20);
  endtask
  // Temporary hold lasts 200 cycles; unlatched flag follows its level
  task automatic t_latch_modes();
    latch_mode <= 4'h1;
    high_sign_in <= 1'b0;
    high_axis_in <= 3'b001;
    high_trig <= 1'b1;
    tick(1);
    high_trig <= 1'b0;
    rd_chk("temp latch set", ADDR_ORIENT_HIGHG, 8'h21);
    tick(200);
    rd_chk("temp latch expired", ADDR_ORIENT_HIGHG, 8'h20);
    latch_mode <= LATCH_NONE;
    high_level <= 1'b1;
    tick(2);
    rd_chk("unlatched level high", ADDR_ORIENT_HIGHG, 8'h21);
    high_level <= 1'b0;
    tick(2);
    rd_chk("unlatched level low", ADDR_ORIENT_HIGHG, 8'h20);
  endtask
  task automatic t_fifo_irq();
    tick(1);
    fifo_wr <= 1'b1;
    tick(33);
    fifo_wr <= 1'b0;
    rd_chk("fifo full overrun", ADDR_FIFO_FILL, 8'ha0);
    chk("irq masked", 8'h00, {7'h0, irq});
    host.write_reg(ADDR_IRQ_MASK, 8'h08);
    tick(1);
    #1;
    chk("irq unmasked", 8'h01, {7'h0, irq});
    tick(1);
    fifo_rd <= 1'b1;
    tick(32);
    fifo_rd <= 1'b0;
    rd_chk("fifo drained", ADDR_FIFO_FILL, 8'h80);
    tick(1);
    fifo_wr <= 1'b1;
    tick(3);
    fifo_wr <= 1'b0;
    rd_chk("fifo three", ADDR_FIFO_FILL, 8'h83);
    host.write_reg(ADDR_FIFO_FILL, 8'h00);
    rd_chk("fifo after write", ADDR_FIFO_FILL, 8'h83);
    tick(1);
    fifo_cfg_wr <= 1'b1;
    tick(1);
    fifo_cfg_wr <= 1'b0;
    rd_chk("fifo cfg clear", ADDR_FIFO_FILL, 8'h00);
    chk("irq sticky", 8'h01, {7'h0, irq});
    host.write_reg(ADDR_IRQ_STATUS, 8'h08);
    tick(1);
    #1;
    chk("irq cleared", 8'h00, {7'h0, irq});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    tick(3);
    t_reset();
    t_range();
    t_filter();
    t_orient();
    t_high_flat();
    t_block();
    t_latch_modes();
    t_fifo_irq();
    report_and_stop();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
